// >>> shared/isr_defines.svh
`ifndef ISR_DEFINES_SVH
`define ISR_DEFINES_SVH

// Summary byte bit positions
`define ISR_STB_UNUSED 0
`define ISR_STB_DEV 1
`define ISR_STB_QUE 2
`define ISR_STB_QUAL 3
`define ISR_STB_MAV 4
`define ISR_STB_ESB 5
`define ISR_STB_RQS 6
`define ISR_STB_OPR 7

// Standard event bit positions
`define ISR_ESR_OPC 0
`define ISR_ESR_QRY 2
`define ISR_ESR_DEV 3
`define ISR_ESR_EXE 4
`define ISR_ESR_CMD 5
`define ISR_ESR_PON 7
`define ISR_ESR_USED 8'hBD
`define ISR_ESR_RESET 8'h80
`define ISR_ESE_RESET 8'h00
`define ISR_SRE_RESET 8'h00

// Quality group bit positions
`define ISR_Q_POWER 3
`define ISR_Q_CAL 8
`define ISR_Q_SELFTEST 9

// 16-bit group layout and reset values
`define ISR_GRP_USED 16'h7FFF
`define ISR_PTR_PRESET 16'hFFFF
`define ISR_NTR_PRESET 16'h0000
`define ISR_EN_RESET 16'h0000
`define ISR_GRP_CLEAR 16'h0000

`endif

// >>> shared/isr_pkg.sv
package isr_pkg;

    typedef enum logic [4:0] {
        ISR_OP_NOP = 5'h00,
        ISR_OP_CLS = 5'h01,
        ISR_OP_PRESET = 5'h02,
        ISR_OP_SRE_WR = 5'h03,
        ISR_OP_SRE_RD = 5'h04,
        ISR_OP_ESE_WR = 5'h05,
        ISR_OP_ESE_RD = 5'h06,
        ISR_OP_ESR_RD = 5'h07,
        ISR_OP_STB_RD = 5'h08,
        ISR_OP_OPC = 5'h09,
        ISR_OP_EN_WR = 5'h0A,
        ISR_OP_EN_RD = 5'h0B,
        ISR_OP_EV_RD = 5'h0C,
        ISR_OP_COND_RD = 5'h0D,
        ISR_OP_PTR_WR = 5'h0E,
        ISR_OP_PTR_RD = 5'h0F,
        ISR_OP_NTR_WR = 5'h10,
        ISR_OP_NTR_RD = 5'h11
    } isr_op_t;

    typedef enum logic [1:0] {
        ISR_GRP_QUAL = 2'h0,
        ISR_GRP_OPER = 2'h1,
        ISR_GRP_DEVC = 2'h2
    } isr_grp_t;

    typedef struct packed {
        isr_op_t op;
        isr_grp_t grp;
        logic [15:0] data;
    } isr_cmd_t;

    typedef struct packed {
        logic qry;
        logic dev;
        logic exe;
        logic cmd;
    } isr_err_t;

    typedef struct packed {
        logic data_error;
        logic meas_clean;
        logic cal_error;
        logic cal_ok;
        logic selftest_fail;
        logic selftest_pass;
    } isr_qual_evt_t;

    typedef enum logic {
        ISR_OPC_IDLE = 1'b0,
        ISR_OPC_ARMED = 1'b1
    } isr_opc_st_t;

endpackage : isr_pkg

// >>> verilog/isr_status_group.sv
`timescale 1ns/1ps
`default_nettype none
`include "isr_defines.svh"

module isr_status_group import isr_pkg::*; #(
    parameter int W = 16
) (
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input wire logic [W-1:0] cond_i,
    input wire logic [W-1:0] evt_i,
    input wire logic [W-1:0] used_i,
    input wire logic preset_i,
    input wire logic clear_i,
    input wire logic en_wr_i,
    input wire logic ptr_wr_i,
    input wire logic ntr_wr_i,
    input wire logic [W-1:0] wdata_i,
    output logic [W-1:0] event_o,
    output logic [W-1:0] enable_o,
    output logic [W-1:0] ptr_o,
    output logic [W-1:0] ntr_o,
    output logic summary_o
);

    logic [W-1:0] prev_cond, next_prev_cond;
    logic [W-1:0] next_event, next_enable, next_ptr, next_ntr;
    logic [W-1:0] hit;

    always_comb begin
        hit = (cond_i & ~prev_cond & ptr_o) | (~cond_i & prev_cond & ntr_o) | evt_i;
        next_prev_cond = cond_i;
        // Set wins over the clear
        next_event = ((clear_i ? W'(0) : event_o) | hit) & used_i;
        next_enable = en_wr_i ? (wdata_i & used_i) : enable_o;
        next_ptr = ptr_o;
        next_ntr = ntr_o;
        if (preset_i) begin
            next_ptr = W'(`ISR_PTR_PRESET) & used_i;
            next_ntr = W'(`ISR_NTR_PRESET);
        end else begin
            if (ptr_wr_i) begin
                next_ptr = wdata_i & used_i;
            end
            if (ntr_wr_i) begin
                next_ntr = wdata_i & used_i;
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            prev_cond <= W'(0);
            event_o <= W'(0);
            enable_o <= W'(`ISR_EN_RESET);
            ptr_o <= W'(`ISR_PTR_PRESET) & W'(`ISR_GRP_USED);
            ntr_o <= W'(`ISR_NTR_PRESET);
        end else begin
            prev_cond <= next_prev_cond;
            event_o <= next_event;
            enable_o <= next_enable;
            ptr_o <= next_ptr;
            ntr_o <= next_ntr;
        end
    end

    assign summary_o = |(event_o & enable_o);

endmodule : isr_status_group
`default_nettype wire

// >>> verilog/isr_std_event.sv
`timescale 1ns/1ps
`default_nettype none
`include "isr_defines.svh"

module isr_std_event import isr_pkg::*; (
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input wire logic [7:0] set_i,
    input wire logic clear_i,
    input wire logic ese_wr_i,
    input wire logic [7:0] wdata_i,
    output logic [7:0] event_o,
    output logic [7:0] enable_o,
    output logic summary_o
);

    logic [7:0] next_event, next_enable;

    always_comb begin
        next_event = ((clear_i ? 8'h00 : event_o) | set_i) & `ISR_ESR_USED;
        next_enable = ese_wr_i ? wdata_i : enable_o;
    end

    // Power-on flag comes up set out of reset
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            event_o <= `ISR_ESR_RESET;
            enable_o <= `ISR_ESE_RESET;
        end else begin
            event_o <= next_event;
            enable_o <= next_enable;
        end
    end

    assign summary_o = |(event_o & enable_o);

endmodule : isr_std_event
`default_nettype wire

// >>> verilog/isr_top.sv
// Overview of operation
// - Quality and operation groups are 16 bits; summary and standard event 8.
// - Top bit of every 16-bit group is unused and reads zero.
// - Message-available bit is set while response data waits.
// - Message-available clears only once all buffered messages are read.
// - Clearing an event register clears its summary bit.
// - Summary bit 0 zero; group summaries at 2, 8, 32, 128 from enabled bits.
// - Weight 4 tracks a non-empty error queue.
// - Querying a group event register clears its summary bit.
// - Service-request mask clears only at power-up or a write of zero.
// - Summary query equals serial poll but keeps request-service bit.
// - Summary query runs in command order and changes nothing.
// - Bit 0 sets once overlapped work after a completion request ends.
// - Error weights: query 4, device 8, execution 16, syntax 32.
// - Weight 128 flags power-up since last read; weights 2 and 64 zero.
// - Standard event register clears on clear-status and on its query.
// - Standard event mask clears only at power-up or a write of zero.
// - Enabled standard events fold into the standard event summary.
// - Enabled quality events fold into the quality summary bit.
// - Quality bit 3 sets on data errors, clears after a clean measurement.
// - Quality bit 8 sets on zero/cal errors, clears on clean success.
// - Quality bit 9 follows the power-on self test result.
// - Events latch on filtered edges; preset gives falling 0, rising 1.
// - A set event bit holds until its query or a clear-status.
// - Group summary is OR of event AND enable over all bits.
// - Service request asserts when an enabled summary bit is set.
`timescale 1ns/1ps
`default_nettype none
`include "isr_defines.svh"

module isr_top import isr_pkg::*; (
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input wire logic cmd_valid_i,
    input wire isr_cmd_t cmd_i,
    input wire logic serial_poll_i,
    input wire logic out_queue_nonempty_i,
    input wire logic err_queue_nonempty_i,
    input wire logic overlapped_busy_i,
    input wire isr_err_t err_i,
    input wire isr_qual_evt_t qual_evt_i,
    input wire logic [15:0] oper_cond_i,
    input wire logic [15:0] dev_cond_i,
    input wire logic [15:0] dev_evt_i,
    output logic resp_valid_o,
    output logic [15:0] resp_data_o,
    output logic [7:0] poll_byte_o,
    output logic srq_o
);

    localparam int NGRP = 3;

    ////////////////////////////////////////////////////////////////////////
    // Command decode

    logic [NGRP-1:0] grp_sel;
    logic is_cls, is_preset, is_sre_wr, is_ese_wr, is_esr_rd, is_stb_rd, is_opc;
    logic is_en_wr, is_ev_rd, is_ptr_wr, is_ntr_wr;

    always_comb begin
        grp_sel = '0;
        grp_sel[cmd_i.grp] = cmd_valid_i;
        is_cls = cmd_valid_i && (cmd_i.op == ISR_OP_CLS);
        is_preset = cmd_valid_i && (cmd_i.op == ISR_OP_PRESET);
        is_sre_wr = cmd_valid_i && (cmd_i.op == ISR_OP_SRE_WR);
        is_ese_wr = cmd_valid_i && (cmd_i.op == ISR_OP_ESE_WR);
        is_esr_rd = cmd_valid_i && (cmd_i.op == ISR_OP_ESR_RD);
        is_stb_rd = cmd_valid_i && (cmd_i.op == ISR_OP_STB_RD);
        is_opc = cmd_valid_i && (cmd_i.op == ISR_OP_OPC);
        is_en_wr = cmd_valid_i && (cmd_i.op == ISR_OP_EN_WR);
        is_ev_rd = cmd_valid_i && (cmd_i.op == ISR_OP_EV_RD);
        is_ptr_wr = cmd_valid_i && (cmd_i.op == ISR_OP_PTR_WR);
        is_ntr_wr = cmd_valid_i && (cmd_i.op == ISR_OP_NTR_WR);
    end

    ////////////////////////////////////////////////////////////////////////
    // Quality condition bits

    logic [15:0] qual_cond, next_qual_cond;

    always_comb begin
        next_qual_cond = qual_cond;
        // Set wins when both arrive together
        if (qual_evt_i.meas_clean) next_qual_cond[`ISR_Q_POWER] = 1'b0;
        if (qual_evt_i.data_error) next_qual_cond[`ISR_Q_POWER] = 1'b1;
        if (qual_evt_i.cal_ok) next_qual_cond[`ISR_Q_CAL] = 1'b0;
        if (qual_evt_i.cal_error) next_qual_cond[`ISR_Q_CAL] = 1'b1;
        if (qual_evt_i.selftest_pass) next_qual_cond[`ISR_Q_SELFTEST] = 1'b0;
        if (qual_evt_i.selftest_fail) next_qual_cond[`ISR_Q_SELFTEST] = 1'b1;
    end

    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            qual_cond <= 16'h0000;
        end else begin
            qual_cond <= next_qual_cond;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // 16-bit status groups

    logic [15:0] grp_cond [NGRP];
    logic [15:0] grp_evt [NGRP];
    logic [15:0] grp_event [NGRP];
    logic [15:0] grp_enable [NGRP];
    logic [15:0] grp_ptr [NGRP];
    logic [15:0] grp_ntr [NGRP];
    logic [NGRP-1:0] grp_sum;

    assign grp_cond[ISR_GRP_QUAL] = qual_cond;
    assign grp_cond[ISR_GRP_OPER] = oper_cond_i;
    assign grp_cond[ISR_GRP_DEVC] = dev_cond_i;
    assign grp_evt[ISR_GRP_QUAL] = 16'h0000;
    assign grp_evt[ISR_GRP_OPER] = 16'h0000;
    assign grp_evt[ISR_GRP_DEVC] = dev_evt_i;

    generate
        for (genvar g = 0; g < NGRP; g++) begin : g_grp
            isr_status_group #(
                .W(16)
            ) u_grp (
                .clk_sys_i(clk_sys_i),
                .nrst_i(nrst_i),
                .cond_i(grp_cond[g]),
                .evt_i(grp_evt[g]),
                .used_i(`ISR_GRP_USED),
                .preset_i(is_preset),
                .clear_i(is_cls || (is_ev_rd && grp_sel[g])),
                .en_wr_i(is_en_wr && grp_sel[g]),
                .ptr_wr_i(is_ptr_wr && grp_sel[g]),
                .ntr_wr_i(is_ntr_wr && grp_sel[g]),
                .wdata_i(cmd_i.data),
                .event_o(grp_event[g]),
                .enable_o(grp_enable[g]),
                .ptr_o(grp_ptr[g]),
                .ntr_o(grp_ntr[g]),
                .summary_o(grp_sum[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Operation-complete tracking and standard events

    isr_opc_st_t opc_st, next_opc_st;
    logic opc_done;
    logic [7:0] esr_set, esr_event, esr_enable;
    logic std_event_summary_bit;

    always_comb begin
        next_opc_st = opc_st;
        opc_done = 1'b0;
        case (opc_st)
            ISR_OPC_IDLE: begin
                if (is_opc) next_opc_st = ISR_OPC_ARMED;
            end
            ISR_OPC_ARMED: begin
                if (!overlapped_busy_i) begin
                    opc_done = 1'b1;
                    next_opc_st = ISR_OPC_IDLE;
                end else if (is_cls) begin
                    next_opc_st = ISR_OPC_IDLE;
                end
            end
            default: next_opc_st = ISR_OPC_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            opc_st <= ISR_OPC_IDLE;
        end else begin
            opc_st <= next_opc_st;
        end
    end

    always_comb begin
        esr_set = 8'h00;
        esr_set[`ISR_ESR_OPC] = opc_done;
        esr_set[`ISR_ESR_QRY] = err_i.qry;
        esr_set[`ISR_ESR_DEV] = err_i.dev;
        esr_set[`ISR_ESR_EXE] = err_i.exe;
        esr_set[`ISR_ESR_CMD] = err_i.cmd;
    end

    isr_std_event u_esr (
        .clk_sys_i(clk_sys_i),
        .nrst_i(nrst_i),
        .set_i(esr_set),
        .clear_i(is_cls || is_esr_rd),
        .ese_wr_i(is_ese_wr),
        .wdata_i(cmd_i.data[7:0]),
        .event_o(esr_event),
        .enable_o(esr_enable),
        .summary_o(std_event_summary_bit)
    );

    ////////////////////////////////////////////////////////////////////////
    // Summary byte and service request

    logic [7:0] service_request_enable_mask, next_sre;
    logic [7:0] stb_sum, stb_byte;
    logic req_now, req_prev, next_req_prev, request_service_bit, next_rqs;
    logic [7:0] next_poll_byte;

    always_comb begin
        stb_sum = 8'h00;
        stb_sum[`ISR_STB_DEV] = grp_sum[ISR_GRP_DEVC];
        stb_sum[`ISR_STB_QUE] = err_queue_nonempty_i;
        stb_sum[`ISR_STB_QUAL] = grp_sum[ISR_GRP_QUAL];
        stb_sum[`ISR_STB_MAV] = out_queue_nonempty_i;
        stb_sum[`ISR_STB_ESB] = std_event_summary_bit;
        stb_sum[`ISR_STB_OPR] = grp_sum[ISR_GRP_OPER];
        stb_byte = stb_sum;
        stb_byte[`ISR_STB_RQS] = request_service_bit;
        req_now = |(stb_sum & service_request_enable_mask);
        next_req_prev = req_now;
        // New request sets it; a serial poll clears it, set wins
        next_rqs = (req_now && !req_prev) || (request_service_bit && !serial_poll_i);
        next_sre = is_sre_wr ? cmd_i.data[7:0] : service_request_enable_mask;
        next_poll_byte = serial_poll_i ? stb_byte : poll_byte_o;
    end

    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            service_request_enable_mask <= `ISR_SRE_RESET;
            req_prev <= 1'b0;
            request_service_bit <= 1'b0;
            srq_o <= 1'b0;
            poll_byte_o <= 8'h00;
        end else begin
            service_request_enable_mask <= next_sre;
            req_prev <= next_req_prev;
            request_service_bit <= next_rqs;
            srq_o <= next_rqs;
            poll_byte_o <= next_poll_byte;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Query responses, one per query command in arrival order; other commands get none

    logic next_resp_valid;
    logic [15:0] next_resp_data;

    always_comb begin
        next_resp_valid = 1'b0;
        next_resp_data = 16'h0000;
        if (cmd_valid_i) begin
            next_resp_valid = 1'b1;
            case (cmd_i.op)
                ISR_OP_SRE_RD: next_resp_data = {8'h00, service_request_enable_mask};
                ISR_OP_ESE_RD: next_resp_data = {8'h00, esr_enable};
                ISR_OP_ESR_RD: next_resp_data = {8'h00, esr_event};
                ISR_OP_STB_RD: next_resp_data = {8'h00, stb_byte};
                ISR_OP_EN_RD: next_resp_data = grp_enable[cmd_i.grp];
                ISR_OP_EV_RD: next_resp_data = grp_event[cmd_i.grp];
                ISR_OP_COND_RD: next_resp_data = grp_cond[cmd_i.grp] & `ISR_GRP_USED;
                ISR_OP_PTR_RD: next_resp_data = grp_ptr[cmd_i.grp];
                ISR_OP_NTR_RD: next_resp_data = grp_ntr[cmd_i.grp];
                default: next_resp_valid = 1'b0;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            resp_valid_o <= 1'b0;
            resp_data_o <= 16'h0000;
        end else begin
            resp_valid_o <= next_resp_valid;
            resp_data_o <= next_resp_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!nrst_i);

    sequence s_stb_query;
        is_stb_rd;
    endsequence

    sequence s_stb_answer;
        resp_valid_o && resp_data_o[15:8] == 8'h00 && resp_data_o[`ISR_STB_UNUSED] == 1'b0;
    endsequence

    a_stb_bit_zero: assert property (s_stb_query |=> s_stb_answer)
        else $error("summary byte bit 0 or upper bits not zero");

    a_mav_follows: assert property (is_stb_rd |=> resp_data_o[`ISR_STB_MAV] == $past(out_queue_nonempty_i))
        else $error("message available bit does not track the output buffer");

    a_queue_summary: assert property (is_stb_rd |=> resp_data_o[`ISR_STB_QUE] == $past(err_queue_nonempty_i))
        else $error("error queue summary bit wrong");

    a_sre_hold: assert property (!is_sre_wr |=> $stable(service_request_enable_mask))
        else $error("service request mask changed without a write");

    a_esr_clear: assert property (is_esr_rd && esr_set == 8'h00 |=> esr_event == 8'h00 ##1 esr_event == $past(esr_set))
        else $error("standard event register not cleared by its query");

    a_esr_answer: assert property (is_esr_rd |=> resp_valid_o && resp_data_o[7:0] == $past(esr_event))
        else $error("standard event query returned wrong value");

    a_esr_unused: assert property (esr_event[1] == 1'b0 && esr_event[6] == 1'b0)
        else $error("unused standard event bits set");

    a_grp_top_zero: assert property (grp_event[ISR_GRP_QUAL][15] == 1'b0 && grp_enable[ISR_GRP_OPER][15] == 1'b0)
        else $error("group bit 15 not zero");

    a_srq_rise: assert property ($rose(req_now) |=> srq_o [*1])
        else $error("service request not raised for a new enabled summary bit");

    a_stb_keeps_rqs: assert property (request_service_bit && is_stb_rd && !serial_poll_i |=> request_service_bit && $stable(service_request_enable_mask))
        else $error("summary query disturbed the request-service bit");

    a_poll_clears: assert property (request_service_bit && serial_poll_i && !(req_now && !req_prev) |=> !request_service_bit ##0 poll_byte_o[`ISR_STB_RQS])
        else $error("serial poll did not clear request-service bit");

    a_selftest_bit: assert property (qual_evt_i.selftest_fail |=> qual_cond[`ISR_Q_SELFTEST])
        else $error("self test failure not reported");

    a_opc_done: assert property (opc_st == ISR_OPC_ARMED && !overlapped_busy_i |=> esr_event[`ISR_ESR_OPC])
        else $error("operation complete not flagged");

    a_cls_clears: assert property (is_cls && esr_set == 8'h00 && dev_evt_i == 16'h0000 |=> esr_event == 8'h00 ##0 !stb_sum[`ISR_STB_ESB])
        else $error("clear-status did not clear standard events");

endmodule : isr_top
`default_nettype wire

// >>> testbench/isr_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none

module isr_ctrl_model (
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input wire logic srq_i,
    input wire logic handler_en_i,
    input wire logic [3:0] delay_i,
    output logic serial_poll_o
);
    logic [3:0] wait_cnt;
    logic [3:0] next_wait_cnt;
    logic next_poll;

    ////////////////////////////////////////////////////////////////////////////////
    // Serial poll after a programmable response delay
    always_comb begin
        next_wait_cnt = 4'h0;
        next_poll = 1'b0;
        if (srq_i && handler_en_i && !serial_poll_o) begin
            next_wait_cnt = wait_cnt + 4'h1;
            next_poll = (wait_cnt >= delay_i);
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            wait_cnt <= 4'h0;
            serial_poll_o <= 1'b0;
        end else begin
            wait_cnt <= next_wait_cnt;
            serial_poll_o <= next_poll;
        end
    end
endmodule : isr_ctrl_model

`default_nettype wire

// >>> testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench import isr_pkg::*;;
    logic clk_sys_i = 1'b0;
    logic nrst_i = 1'b0;
    logic cmd_valid_i = 1'b0;
    isr_cmd_t cmd_i = '0;
    logic serial_poll;
    logic out_q = 1'b0;
    logic err_q = 1'b0;
    logic busy = 1'b0;
    isr_err_t err_i = '0;
    isr_qual_evt_t qual_evt_i = '0;
    logic [15:0] oper_cond_i = 16'h0000;
    logic [15:0] dev_cond_i = 16'h0000;
    logic [15:0] dev_evt_i = 16'h0000;
    logic handler_en = 1'b0;
    logic resp_valid_o;
    logic [15:0] resp_data_o;
    logic [7:0] poll_byte_o;
    logic srq_o;
    int error_cnt = 0;
    int checked = 0;

    always #2 clk_sys_i = ~clk_sys_i;

    isr_top isr_top_inst (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .cmd_valid_i(cmd_valid_i),
        .cmd_i(cmd_i), .serial_poll_i(serial_poll), .out_queue_nonempty_i(out_q),
        .err_queue_nonempty_i(err_q), .overlapped_busy_i(busy), .err_i(err_i),
        .qual_evt_i(qual_evt_i), .oper_cond_i(oper_cond_i), .dev_cond_i(dev_cond_i),
        .dev_evt_i(dev_evt_i), .resp_valid_o(resp_valid_o), .resp_data_o(resp_data_o),
        .poll_byte_o(poll_byte_o), .srq_o(srq_o));

    isr_ctrl_model isr_ctrl_model_inst (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
        .srq_i(srq_o), .handler_en_i(handler_en), .delay_i(4'h3),
        .serial_poll_o(serial_poll));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        $display("Checks %0d errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : give_verdict

    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic idle(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask : idle

    // Issue one command; a quiet cycle follows so strobes never double up
    task automatic cmd(input isr_op_t op, input isr_grp_t g, input logic [15:0] d);
        cmd_valid_i <= 1'b1;
        cmd_i <= '{op: op, grp: g, data: d};
        @(posedge clk_sys_i);
        cmd_valid_i <= 1'b0;
        @(posedge clk_sys_i);
    endtask : cmd

    // Query; answer is looked at mid-cycle, then realigned to the edge
    task automatic rd(input isr_op_t op, input isr_grp_t g, input logic [15:0] exp,
                      input string nm);
        cmd_valid_i <= 1'b1;
        cmd_i <= '{op: op, grp: g, data: 16'h0000};
        @(posedge clk_sys_i);
        cmd_valid_i <= 1'b0;
        @(negedge clk_sys_i);
        chk("resp_valid", 16'h0001, {15'h0000, resp_valid_o});
        chk(nm, exp, resp_data_o);
        @(posedge clk_sys_i);
    endtask : rd

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge clk_sys_i);
        nrst_i <= 1'b1;
        @(posedge clk_sys_i);
        rd(ISR_OP_ESR_RD, ISR_GRP_QUAL, 16'h0080, "esr_power_on");
        rd(ISR_OP_ESR_RD, ISR_GRP_QUAL, 16'h0000, "esr_after_read");
        rd(ISR_OP_SRE_RD, ISR_GRP_QUAL, 16'h0000, "sre_reset");
        rd(ISR_OP_ESE_RD, ISR_GRP_QUAL, 16'h0000, "ese_reset");
        rd(ISR_OP_PTR_RD, ISR_GRP_QUAL, 16'h7FFF, "ptr_reset");
        rd(ISR_OP_NTR_RD, ISR_GRP_QUAL, 16'h0000, "ntr_reset");
        // Every error kind at once
        err_i <= 4'hF;
        idle(1);
        err_i <= 4'h0;
        idle(2);
        rd(ISR_OP_ESR_RD, ISR_GRP_QUAL, 16'h003C, "esr_errors");
        // Completion request while overlapped work runs
        busy <= 1'b1;
        cmd(ISR_OP_OPC, ISR_GRP_QUAL, 16'h0000);
        idle(3);
        rd(ISR_OP_ESR_RD, ISR_GRP_QUAL, 16'h0000, "esr_opc_busy");
        busy <= 1'b0;
        idle(3);
        rd(ISR_OP_ESR_RD, ISR_GRP_QUAL, 16'h0001, "esr_opc_done");
        // Service request via standard event summary
        cmd(ISR_OP_CLS, ISR_GRP_QUAL, 16'h0000);
        cmd(ISR_OP_ESE_WR, ISR_GRP_QUAL, 16'h0020);
        cmd(ISR_OP_SRE_WR, ISR_GRP_QUAL, 16'h0020);
        err_i <= 4'h1;
        idle(1);
        err_i <= 4'h0;
        idle(3);
        chk("srq", 16'h0001, {15'h0000, srq_o});
        rd(ISR_OP_STB_RD, ISR_GRP_QUAL, 16'h0060, "stb_esb");
        rd(ISR_OP_STB_RD, ISR_GRP_QUAL, 16'h0060, "stb_again");
        handler_en <= 1'b1;
        idle(10);
        handler_en <= 1'b0;
        chk("poll_byte", 16'h0060, {8'h00, poll_byte_o});
        chk("srq_after_poll", 16'h0000, {15'h0000, srq_o});
        rd(ISR_OP_STB_RD, ISR_GRP_QUAL, 16'h0020, "stb_after_poll");
        rd(ISR_OP_ESR_RD, ISR_GRP_QUAL, 16'h0020, "esr_cmd_err");
        rd(ISR_OP_STB_RD, ISR_GRP_QUAL, 16'h0000, "stb_esr_cleared");
        // Message and error queue summaries
        out_q <= 1'b1;
        err_q <= 1'b1;
        idle(1);
        rd(ISR_OP_STB_RD, ISR_GRP_QUAL, 16'h0014, "stb_queues");
        out_q <= 1'b0;
        err_q <= 1'b0;
        idle(1);
        rd(ISR_OP_STB_RD, ISR_GRP_QUAL, 16'h0000, "stb_queues_empty");
        // Quality group
        cmd(ISR_OP_EN_WR, ISR_GRP_QUAL, 16'h0308);
        qual_evt_i <= 6'b100000;
        idle(1);
        qual_evt_i <= 6'b000000;
        idle(3);
        rd(ISR_OP_STB_RD, ISR_GRP_QUAL, 16'h0008, "stb_quality");
        rd(ISR_OP_EV_RD, ISR_GRP_QUAL, 16'h0008, "qual_data_err");
        rd(ISR_OP_STB_RD, ISR_GRP_QUAL, 16'h0000, "stb_qual_read");
        qual_evt_i <= 6'b010000;
        idle(1);
        qual_evt_i <= 6'b001010;
        idle(1);
        qual_evt_i <= 6'b000000;
        idle(3);
        rd(ISR_OP_COND_RD, ISR_GRP_QUAL, 16'h0300, "qual_cond_fail");
        qual_evt_i <= 6'b000101;
        idle(1);
        qual_evt_i <= 6'b000000;
        idle(3);
        rd(ISR_OP_COND_RD, ISR_GRP_QUAL, 16'h0000, "qual_cond_pass");
        rd(ISR_OP_EV_RD, ISR_GRP_QUAL, 16'h0300, "qual_ev_held");
        rd(ISR_OP_EN_RD, ISR_GRP_QUAL, 16'h0308, "qual_en");
        // Operation group top bit
        oper_cond_i <= 16'hFFFF;
        idle(3);
        rd(ISR_OP_EV_RD, ISR_GRP_OPER, 16'h7FFF, "oper_ev");
        rd(ISR_OP_COND_RD, ISR_GRP_OPER, 16'h7FFF, "oper_cond");
        // Device group on falling filter and direct event
        cmd(ISR_OP_PTR_WR, ISR_GRP_DEVC, 16'h0000);
        cmd(ISR_OP_NTR_WR, ISR_GRP_DEVC, 16'h0002);
        cmd(ISR_OP_EN_WR, ISR_GRP_DEVC, 16'h4002);
        dev_cond_i <= 16'h0002;
        idle(3);
        rd(ISR_OP_EV_RD, ISR_GRP_DEVC, 16'h0000, "dev_rise_filtered");
        dev_cond_i <= 16'h0000;
        dev_evt_i <= 16'h4000;
        idle(1);
        dev_evt_i <= 16'h0000;
        idle(3);
        rd(ISR_OP_STB_RD, ISR_GRP_QUAL, 16'h0002, "stb_device");
        rd(ISR_OP_EV_RD, ISR_GRP_DEVC, 16'h4002, "dev_ev");
        cmd(ISR_OP_PRESET, ISR_GRP_QUAL, 16'h0000);
        rd(ISR_OP_PTR_RD, ISR_GRP_DEVC, 16'h7FFF, "ptr_preset");
        rd(ISR_OP_NTR_RD, ISR_GRP_DEVC, 16'h0000, "ntr_preset");
        // Clear-status leaves masks alone
        err_i <= 4'h8;
        idle(1);
        err_i <= 4'h0;
        cmd(ISR_OP_CLS, ISR_GRP_QUAL, 16'h0000);
        rd(ISR_OP_ESR_RD, ISR_GRP_QUAL, 16'h0000, "esr_cls");
        rd(ISR_OP_SRE_RD, ISR_GRP_QUAL, 16'h0020, "sre_kept");
        rd(ISR_OP_ESE_RD, ISR_GRP_QUAL, 16'h0020, "ese_kept");
        cmd(ISR_OP_ESE_WR, ISR_GRP_QUAL, 16'h0000);
        cmd(ISR_OP_SRE_WR, ISR_GRP_QUAL, 16'h0000);
        rd(ISR_OP_ESE_RD, ISR_GRP_QUAL, 16'h0000, "ese_zero");
        rd(ISR_OP_SRE_RD, ISR_GRP_QUAL, 16'h0000, "sre_zero");
        // Power cycle in mid-run
        cmd(ISR_OP_SRE_WR, ISR_GRP_QUAL, 16'h0010);
        nrst_i <= 1'b0;
        idle(2);
        nrst_i <= 1'b1;
        idle(1);
        rd(ISR_OP_SRE_RD, ISR_GRP_QUAL, 16'h0000, "sre_power_cycle");
        rd(ISR_OP_ESR_RD, ISR_GRP_QUAL, 16'h0080, "esr_power_cycle");
        give_verdict();
    end

    initial begin
        repeat (5000) @(posedge clk_sys_i);
        error_cnt++;
        give_verdict();
    end
endmodule : testbench

`default_nettype wire
